//--- logic/irq_bank_map.svh
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_ENABLE0       12'h000
`define ADDR_PRIO_SER      12'h004
`define ADDR_PRIO_EXT      12'h008
`define ADDR_PENDING       12'h00c

// ----------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------
`define ENABLE0_MASK       16'h3fef
`define ENABLE0_RESET      16'h0000
`define PRIO_SER_MASK      16'h7777
`define PRIO_SER_RESET     16'h4444
`define PRIO_EXT_MASK_T5   16'h0077
`define PRIO_EXT_MASK_NOT5 16'h0070
`define PRIO_EXT_RESET     16'h0044

// ----------------------------------------------------------------
// Field positions (low bit of each field)
// ----------------------------------------------------------------
`define EN_ADC_DONE        13
`define EN_SER_TX          12
`define EN_SER_RX          11
`define EN_SPI_EVT         10
`define EN_SPI_ERR         9
`define EN_TIMER3          8
`define EN_TIMER2          7
`define EN_CMP2            6
`define EN_CAP2            5
`define EN_TIMER1          3
`define EN_CMP1            2
`define EN_CAP1            1
`define EN_EXT0            0
`define LVL_SER_RX         12
`define LVL_SPI_EVT        8
`define LVL_SPI_ERR        4
`define LVL_TIMER3         0
`define LVL_EXT2           4
`define LVL_TIMER5         0

`endif

//--- logic/irq_bank_pkg.sv
package irq_bank_pkg;

	// AHB-Lite request captured in the address phase
	typedef struct packed {
		logic        pend;
		logic        write;
		logic [11:0] addr;
	} ahb_req_t;

	// Register bank state
	typedef struct packed {
		ahb_req_t    req;
		logic [15:0] enable0;
		logic [15:0] prio_ser;
		logic [15:0] prio_ext;
		logic [31:0] rdata;
	} bank_state_t;

	// Source requests from peripherals
	typedef struct packed {
		logic adc_done;
		logic ser_tx;
		logic ser_rx;
		logic spi_evt;
		logic spi_err;
		logic timer3;
		logic timer2;
		logic cmp2;
		logic cap2;
		logic timer1;
		logic cmp1;
		logic cap1;
		logic ext0;
		logic ext2;
		logic timer5;
	} irq_src_t;

endpackage : irq_bank_pkg

//--- logic/irq_src_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for peripheral request lines
module irq_src_sync #(
	parameter int W = 15
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Lines
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// First stage only feeds the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : irq_src_sync

//--- logic/irq_enable_priority_regs.sv
// Operation
// - Enable bits 13..8: ADC, serial tx/rx, SPI event/error, timer3.
// - Enable bits 7,6,5,3,2,1,0 gate timer2 to ext0; bit 4 unused.
// - Enable bits are R/W, reset to 0; bits 15-14 unimplemented.
// - Priorities are 3 bits: 7 highest, 1 lowest, 0 disables the source.
// - Level reg 1: serial rx 14-12, SPI 10-8, SPI error 6-4, timer3 2-0.
// - Every implemented priority field resets to binary 100.
// - Level reg 2: ext2 at 6-4, timer5 at 2-0, other bits unimplemented.
// - The timer5 level field exists only when a parameter selects it.
// - Unimplemented bits always read as zero.
`timescale 1ns/1ps
`include "irq_bank_map.svh"

module irq_enable_priority_regs
	import irq_bank_pkg::*;
#(
	parameter bit HAS_TIMER5 = 1'b1
) (
	// AHB-Lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Peripheral request lines (asynchronous)
	input  wire irq_src_t    src_req,
	// Gated requests and levels toward the core
	output irq_src_t         irq_out,
	output logic      [2:0]  timer5_irq_level
);

	bank_state_t state_ff;
	bank_state_t nxt_state;
	irq_src_t    src_sync;
	irq_src_t    nxt_irq;
	irq_src_t    irq_ff;
	logic [15:0] ext_mask;

	// ----------------------------------------------------------------
	// Request synchroniser
	// ----------------------------------------------------------------
	irq_src_sync #(.W($bits(irq_src_t))) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (src_req),
		.sync_out (src_sync)
	);

	// timer5 field only on the larger build
	assign ext_mask = HAS_TIMER5 ? `PRIO_EXT_MASK_T5 : `PRIO_EXT_MASK_NOT5;

	// Three-bit level extraction, used for the six level-gated sources
	function automatic logic [2:0] lvl(input logic [15:0] r, input int lsb);
		lvl = 3'((r >> lsb) & 16'h0007);
	endfunction : lvl

	// code 000 disables, any other code passes when en is set
	function automatic logic pass(input logic en, input logic [2:0] l);
		pass = en && (l != 3'h0);
	endfunction : pass

	// ----------------------------------------------------------------
	// Register bank and bus next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		// Data phase: a write lands one cycle after its address
		if (state_ff.req.pend && state_ff.req.write) begin
			unique case (state_ff.req.addr)
				`ADDR_ENABLE0:
					nxt_state.enable0 = hwdata[15:0] & `ENABLE0_MASK;
				`ADDR_PRIO_SER:
					nxt_state.prio_ser = hwdata[15:0] & `PRIO_SER_MASK;
				`ADDR_PRIO_EXT:
					nxt_state.prio_ext = hwdata[15:0] & ext_mask;
				default: ;
			endcase
		end
		// Address phase capture; slave is always ready
		nxt_state.req.pend  = hsel && hready && htrans[1];
		nxt_state.req.write = hwrite;
		nxt_state.req.addr  = haddr;
		// Read data prepared for the data phase
		nxt_state.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			// unimplemented bits stored as zero, read zero
			unique case (haddr)
				`ADDR_ENABLE0:  nxt_state.rdata = {16'h0000, state_ff.enable0};
				`ADDR_PRIO_SER: nxt_state.rdata = {16'h0000, state_ff.prio_ser};
				`ADDR_PRIO_EXT: nxt_state.rdata = {16'h0000, state_ff.prio_ext};
				`ADDR_PENDING:
					nxt_state.rdata = {17'h00000, irq_ff};
				default:        nxt_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff.req      <= '0;
			state_ff.enable0  <= `ENABLE0_RESET;
			state_ff.prio_ser <= `PRIO_SER_RESET;
			// absent timer5 field resets to zero
			state_ff.prio_ext <= HAS_TIMER5 ? `PRIO_EXT_RESET
				: (`PRIO_EXT_RESET & `PRIO_EXT_MASK_NOT5);
			state_ff.rdata    <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Request gating
	// ----------------------------------------------------------------
	always_comb begin
		nxt_irq.adc_done = src_sync.adc_done
			&& state_ff.enable0[`EN_ADC_DONE];
		nxt_irq.ser_tx   = src_sync.ser_tx && state_ff.enable0[`EN_SER_TX];
		nxt_irq.ser_rx   = src_sync.ser_rx && pass(
			state_ff.enable0[`EN_SER_RX], lvl(state_ff.prio_ser, `LVL_SER_RX));
		nxt_irq.spi_evt  = src_sync.spi_evt && pass(
			state_ff.enable0[`EN_SPI_EVT], lvl(state_ff.prio_ser, `LVL_SPI_EVT));
		nxt_irq.spi_err  = src_sync.spi_err && pass(
			state_ff.enable0[`EN_SPI_ERR], lvl(state_ff.prio_ser, `LVL_SPI_ERR));
		nxt_irq.timer3   = src_sync.timer3 && pass(
			state_ff.enable0[`EN_TIMER3], lvl(state_ff.prio_ser, `LVL_TIMER3));
		nxt_irq.timer2   = src_sync.timer2 && state_ff.enable0[`EN_TIMER2];
		nxt_irq.cmp2     = src_sync.cmp2 && state_ff.enable0[`EN_CMP2];
		nxt_irq.cap2     = src_sync.cap2 && state_ff.enable0[`EN_CAP2];
		nxt_irq.timer1   = src_sync.timer1 && state_ff.enable0[`EN_TIMER1];
		nxt_irq.cmp1     = src_sync.cmp1 && state_ff.enable0[`EN_CMP1];
		nxt_irq.cap1     = src_sync.cap1 && state_ff.enable0[`EN_CAP1];
		nxt_irq.ext0     = src_sync.ext0 && state_ff.enable0[`EN_EXT0];
		// Sources whose enable bits live outside this bank: level only
		nxt_irq.ext2     = src_sync.ext2
			&& pass(1'b1, lvl(state_ff.prio_ext, `LVL_EXT2));
		nxt_irq.timer5   = src_sync.timer5 && HAS_TIMER5
			&& pass(1'b1, lvl(state_ff.prio_ext, `LVL_TIMER5));
	end

	// Registered so the core sees glitch-free requests
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= '0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign irq_out          = irq_ff;
	assign timer5_irq_level = lvl(state_ff.prio_ext, `LVL_TIMER5);
	assign hrdata           = state_ff.rdata;
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_wr_enable;
		hsel && hready && htrans[1] && hwrite && haddr == `ADDR_ENABLE0;
	endsequence

	property p_enable_write;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_enable ##1 1'b1 |=> state_ff.enable0
			== ($past(hwdata[15:0]) & 16'h3fef);
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("enable write not stored");

	property p_bit4_zero;
		@(posedge hclk) disable iff (!hresetn)
		!state_ff.enable0[4] && state_ff.enable0[15:14] == 2'b00;
	endproperty
	a_bit4_zero: assert property (p_bit4_zero)
		else $error("unimplemented enable bit set");

	property p_enable_reset;
		@(posedge hclk) $rose(hresetn) |-> state_ff.enable0 == 16'h0000;
	endproperty
	a_enable_reset: assert property (p_enable_reset)
		else $error("enable not cleared by reset");

	property p_level_zero_blocks;
		@(posedge hclk) disable iff (!hresetn)
		state_ff.prio_ser[2:0] == 3'h0 |=> !irq_ff.timer3;
	endproperty
	a_level_zero_blocks: assert property (p_level_zero_blocks)
		else $error("level 0 did not block timer3");

	property p_prio_ser_gaps;
		@(posedge hclk) disable iff (!hresetn)
		(state_ff.prio_ser & 16'h8888) == 16'h0000;
	endproperty
	a_prio_ser_gaps: assert property (p_prio_ser_gaps)
		else $error("priority gap bit set");

	property p_prio_reset;
		@(posedge hclk) $rose(hresetn) |-> state_ff.prio_ser == 16'h4444
			&& state_ff.prio_ext == (HAS_TIMER5 ? 16'h0044 : 16'h0040);
	endproperty
	a_prio_reset: assert property (p_prio_reset)
		else $error("priority reset not 100");

	property p_prio_ext_high;
		@(posedge hclk) disable iff (!hresetn)
		state_ff.prio_ext[15:7] == 9'h000 && !state_ff.prio_ext[3];
	endproperty
	a_prio_ext_high: assert property (p_prio_ext_high)
		else $error("second priority high bits set");

	property p_timer5_absent;
		@(posedge hclk) disable iff (!hresetn)
		!HAS_TIMER5 |-> !irq_ff.timer5;
	endproperty
	a_timer5_absent: assert property (p_timer5_absent)
		else $error("timer5 request without field");

	property p_read_upper_zero;
		@(posedge hclk) disable iff (!hresetn)
		hsel && hready && htrans[1] && !hwrite |=> hrdata[31:16] == 16'h0000;
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero)
		else $error("upper read bits nonzero");

	property p_gate_path;
		@(posedge hclk) disable iff (!hresetn)
		irq_ff.ser_rx |-> $past(state_ff.enable0[11])
			&& $past(state_ff.prio_ser[14:12]) != 3'h0;
	endproperty
	a_gate_path: assert property (p_gate_path)
		else $error("serial rx passed while gated");

	sequence s_wr_prio_ser;
		hsel && hready && htrans[1] && hwrite && haddr == `ADDR_PRIO_SER;
	endsequence

	property p_prio_ser_write;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_prio_ser ##1 1'b1 |=> state_ff.prio_ser
			== ($past(hwdata[15:0]) & 16'h7777);
	endproperty
	a_prio_ser_write: assert property (p_prio_ser_write)
		else $error("priority write not stored");

	sequence s_wr_prio_ext;
		hsel && hready && htrans[1] && hwrite && haddr == `ADDR_PRIO_EXT;
	endsequence

	// Absent timer5 field must drop its bits on write
	property p_prio_ext_write;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_prio_ext ##1 1'b1 |=> state_ff.prio_ext == ($past(hwdata[15:0])
			& (HAS_TIMER5 ? 16'h0077 : 16'h0070));
	endproperty
	a_prio_ext_write: assert property (p_prio_ext_write)
		else $error("second priority write not stored");

	sequence s_wr_unmapped;
		hsel && hready && htrans[1] && hwrite && haddr != `ADDR_ENABLE0
			&& haddr != `ADDR_PRIO_SER && haddr != `ADDR_PRIO_EXT;
	endsequence

	property p_unmapped_write;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_unmapped ##1 1'b1 |=> $stable({state_ff.enable0,
			state_ff.prio_ser, state_ff.prio_ext});
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("unmapped write changed a register");

	sequence s_rd_enable;
		hsel && hready && htrans[1] && !hwrite && haddr == `ADDR_ENABLE0;
	endsequence

	property p_read_enable;
		@(posedge hclk) disable iff (!hresetn)
		s_rd_enable |=> hrdata == {16'h0000, $past(state_ff.enable0)};
	endproperty
	a_read_enable: assert property (p_read_enable)
		else $error("enable read data wrong");

	property p_adc_blocked;
		@(posedge hclk) disable iff (!hresetn)
		!state_ff.enable0[`EN_ADC_DONE] |=> !irq_ff.adc_done;
	endproperty
	a_adc_blocked: assert property (p_adc_blocked)
		else $error("adc request passed while disabled");

	property p_ext0_blocked;
		@(posedge hclk) disable iff (!hresetn)
		!state_ff.enable0[`EN_EXT0] |=> !irq_ff.ext0;
	endproperty
	a_ext0_blocked: assert property (p_ext0_blocked)
		else $error("ext0 request passed while disabled");

	property p_ext2_level_zero;
		@(posedge hclk) disable iff (!hresetn)
		state_ff.prio_ext[6:4] == 3'h0 |=> !irq_ff.ext2;
	endproperty
	a_ext2_level_zero: assert property (p_ext2_level_zero)
		else $error("level 0 did not block ext2");

	property p_timer5_level;
		@(posedge hclk) disable iff (!hresetn)
		!HAS_TIMER5 |-> timer5_irq_level == 3'h0;
	endproperty
	a_timer5_level: assert property (p_timer5_level)
		else $error("timer5 level shown without field");

endmodule : irq_enable_priority_regs

//--- bench/irq_source_model.sv
`timescale 1ns/1ps

// Peripheral request lines: levels follow the bench's pattern after a
// chosen number of clocks, so prompt and late sources are both possible
module irq_source_model
	import irq_bank_pkg::*;
(
	// Clock
	input  wire logic       hclk,
	// Control from the bench
	input  wire irq_src_t   pattern,
	input  wire logic [3:0] lag,
	// Requests toward the bank
	output irq_src_t        src_req
);
	irq_src_t    pipe_ff [16];

	// Delay line; requests are plain levels, no handshake
	always @(posedge hclk) begin
		pipe_ff[0] <= pattern;
		for (int i = 1; i < 16; i++) begin
			pipe_ff[i] <= pipe_ff[i-1];
		end
	end
	assign src_req = (lag == 4'h0) ? pattern : pipe_ff[lag-4'h1];
endmodule : irq_source_model

//--- bench/irq_enable_priority_regs_bench.sv
`timescale 1ns/1ps

module irq_enable_priority_regs_bench;
	import irq_bank_pkg::*;

	// Bus and source signals
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	irq_src_t    pattern = '0;
	logic [3:0]  lag = 4'h0;
	irq_src_t    src_req;
	irq_src_t    irq_out;
	logic [2:0]  t5_level;
	logic [31:0] rd;
	logic [31:0] rd_s;
	logic [31:0] hrdata_s;
	irq_src_t    irq_s;
	logic [2:0]  t5_s;
	int          err_total = 0;
	int          cmp_count = 0;

	always #12.5 hclk = ~hclk;

	irq_enable_priority_regs i_dut (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.hsel             (hsel),
		.haddr            (haddr),
		.htrans           (htrans),
		.hwrite           (hwrite),
		.hsize            (hsize),
		.hwdata           (hwdata),
		.hready           (hreadyout),
		.hrdata           (hrdata),
		.hreadyout        (hreadyout),
		.hresp            (hresp),
		.src_req          (src_req),
		.irq_out          (irq_out),
		.timer5_irq_level (t5_level)
	);

	// Build without the timer5 field, on the same bus and sources
	irq_enable_priority_regs #(.HAS_TIMER5(1'b0)) i_dut_small (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.hsel             (hsel),
		.haddr            (haddr),
		.htrans           (htrans),
		.hwrite           (hwrite),
		.hsize            (hsize),
		.hwdata           (hwdata),
		.hready           (hreadyout),
		.hrdata           (hrdata_s),
		.hreadyout        (),
		.hresp            (),
		.src_req          (src_req),
		.irq_out          (irq_s),
		.timer5_irq_level (t5_s)
	);

	irq_source_model i_src (
		.hclk    (hclk),
		.pattern (pattern),
		.lag     (lag),
		.src_req (src_req)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Single word transfer; waits on hready, takes data at its edge
	task automatic xfer(input logic wr, input logic [11:0] a,
			input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		rd_s = hrdata_s;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask : xfer

	// Requests cross two sync stages and one output flop
	task automatic check_irq(input logic [14:0] exp);
		repeat (6) @(posedge hclk);
		check("irq_out", {17'h0, irq_out}, {17'h0, exp});
	endtask : check_irq

	task automatic report_and_stop;
		$display("Compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values of all three registers
		xfer(1'b0, 12'h000, 32'h0); check("en rst", rd, 32'h0);
		xfer(1'b0, 12'h004, 32'h0); check("ps rst", rd, 32'h4444);
		xfer(1'b0, 12'h008, 32'h0); check("pe rst", rd, 32'h0044);
		check("pe rst s", rd_s, 32'h0040);
		pattern <= 15'h7fff;
		// Only the level-gated ext2 and timer5 pass with enables off; the small build passes ext2 alone
		check_irq(15'h0003);
		check("irq small", {17'h0, irq_s}, 32'h2);
		$display("Test reset values done");
		// All ones written: unimplemented bits read zero
		xfer(1'b1, 12'h000, 32'hffffffff);
		xfer(1'b0, 12'h000, 32'h0); check("en ones", rd, 32'h3fef);
		xfer(1'b1, 12'h004, 32'hffffffff);
		xfer(1'b0, 12'h004, 32'h0); check("ps ones", rd, 32'h7777);
		xfer(1'b1, 12'h008, 32'hffffffff);
		xfer(1'b0, 12'h008, 32'h0); check("pe ones", rd, 32'h0077);
		check("pe ones s", rd_s, 32'h0070);
		xfer(1'b1, 12'h010, 32'hffffffff);
		xfer(1'b0, 12'h010, 32'h0); check("unmapped", rd, 32'h0);
		check("t5 level", {29'h0, t5_level}, 32'h7);
		check("t5 small", {29'h0, t5_s}, 32'h0);
		$display("Test masks done");
		// Gating by enable and by priority code
		check_irq(15'h7fff);
		xfer(1'b0, 12'h00c, 32'h0); check("status", rd, 32'h7fff);
		xfer(1'b1, 12'h004, 32'h00000777);
		check_irq(15'h6fff);
		// Timer3 level 0 as well
		xfer(1'b1, 12'h004, 32'h00000770);
		check_irq(15'h6dff);
		xfer(1'b1, 12'h000, 32'h00001fef);
		check_irq(15'h2dff);
		xfer(1'b1, 12'h000, 32'h0000000f);
		check_irq(15'h003f);
		xfer(1'b1, 12'h008, 32'h00000007);
		check_irq(15'h003d);
		// Late sources: old requests hold until the zero pattern arrives
		lag <= 4'h9;
		pattern <= 15'h0000;
		check_irq(15'h003d);
		repeat (8) @(posedge hclk);
		check("irq late", {17'h0, irq_out}, 32'h0);
		$display("Test gating done");
		// Reset in mid-run restores the written registers
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, 12'h000, 32'h0); check("en rst2", rd, 32'h0);
		xfer(1'b0, 12'h004, 32'h0); check("ps rst2", rd, 32'h4444);
		xfer(1'b0, 12'h008, 32'h0); check("pe rst2", rd, 32'h0044);
		check("pe rst2 s", rd_s, 32'h0040);
		$display("Test mid-run reset done");
		report_and_stop();
	end

	// Hang guard, well past the 108 clocks of the tests
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
endmodule : irq_enable_priority_regs_bench
